// ### kfm_pkg.sv
// constants, encodings and timing counts of the kiln fault monitor
// assumes a single 25 MHz core clock and temperatures in signed degrees
package kfm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES_DFLT = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam logic [4:0] PERSIST_S = 5'h12;
  localparam logic [8:0] SLOW_WINDOW_S = 9'h1E0;
  localparam logic [1:0] DONE_S = 2'h3;

  // ----------------------------------------------------------------
  // temperature limits
  // ----------------------------------------------------------------
  localparam int TW = 16;
  localparam logic signed [16:0] DEV_LIMIT = 17'sh00032;
  localparam logic signed [16:0] SLOW_MIN_RISE = 17'sh00002;

  // ----------------------------------------------------------------
  // segment types from the sequencer
  // ----------------------------------------------------------------
  localparam logic [1:0] SEG_IDLE = 2'h0;
  localparam logic [1:0] SEG_RAMP_UP = 2'h1;
  localparam logic [1:0] SEG_RAMP_DOWN = 2'h2;
  localparam logic [1:0] SEG_HOLD = 2'h3;

  // ----------------------------------------------------------------
  // error flag positions, bit n holds numbered code n+1
  // ----------------------------------------------------------------
  localparam int ERR_SLOW = 0;
  localparam int ERR_OVER_HOLD = 1;
  localparam int ERR_UNDER_HOLD = 2;
  localparam int ERR_COOL_OVER = 3;
  localparam int ERR_COOL_LAG = 4;
  localparam int ERR_REVERSED = 5;
  localparam int ERR_HEAT_OVER = 6;
  localparam int ERR_FALLING = 7;
  localparam int NUM_TMR = 5;
  localparam int MID_CH = 1;

  // ----------------------------------------------------------------
  // display modes
  // ----------------------------------------------------------------
  localparam logic [3:0] DSP_TEMP = 4'h0;
  localparam logic [3:0] DSP_IDLE = 4'h1;
  localparam logic [3:0] DSP_ERROR = 4'h2;
  localparam logic [3:0] DSP_SHORT = 4'h3;
  localparam logic [3:0] DSP_LONG = 4'h4;
  localparam logic [3:0] DSP_FAIL = 4'h5;
  localparam logic [3:0] DSP_ON = 4'h6;
  localparam logic [3:0] DSP_OFF = 4'h7;
  localparam logic [3:0] DSP_DONE = 4'h8;

  // ----------------------------------------------------------------
  // reset values and menu states
  // ----------------------------------------------------------------
  localparam logic ERR_EN_RST = 1'b1;

  typedef enum logic [1:0] {
    KFM_IDLE = 2'h0,
    KFM_MENU = 2'h1,
    KFM_DONE = 2'h3
  } kfm_state_type;

endpackage

// ### kfm_tmr_if.sv
// interface between the monitor and one persistence timer
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface kfm_tmr_if;
  logic cond;
  logic tick;
  logic expired;
  modport owner (output cond, output tick, input expired);
  modport timer (input cond, input tick, output expired);
endinterface

// ### kfm_persist.sv
// persistence timer for one deviation condition
// assumes a one-cycle tick per second from the owner
`timescale 1ns/1ps
module kfm_persist
  import kfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  kfm_tmr_if.timer bus
);

  logic [4:0] count_q;
  logic [4:0] count_d;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // one extra tick so a condition that starts mid-second still lasts
  // the full interval
  always_comb begin
    count_d = count_q;
    if (!bus.cond) begin
      count_d = 5'h00;
    end else if (bus.tick && count_q != PERSIST_S + 5'h01) begin
      count_d = count_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
    end
  end

  assign bus.expired = (count_q == PERSIST_S + 5'h01);

endmodule // kfm_persist

// ### kfm_top.sv
// kiln fault monitor: deviation, sensor and outage errors, error menu
// assumes sequencer and converter inputs on CORE_CLK, keys on raw pins
`timescale 1ns/1ps

// Operation
// - hold, 50 above for 18 s
// - hold, 50 below for 18 s
// - down ramp, 50 above previous hold
// - down ramp, 50 below moving setpoint
// - up ramp, 50 above moving setpoint
// - negative reading flags reversed sensor
// - cone mode final ramp, temperature falling
// - heating but not getting hotter
// - long outage aborts, shows only outage
// - short outage keeps firing, alternates, key 1
// - power lost during program write reported
// - per-channel sensor fail; shorted reads normally
// - error codes on after reset
// - codes off also disables zone balancing
// - reversed, fail, outage never masked
// - slow and falling kept in final cone
// - menu shows On/OFF, key 1 toggles
module kfm_top
  import kfm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [2:0][15:0] TEMP_CH,
  input wire logic [2:0] TC_OPEN,
  input wire logic FIRING,
  input wire logic FIRING_START,
  input wire logic [1:0] SEG_TYPE,
  input wire logic CONE_MODE,
  input wire logic LAST_SEGMENT,
  input wire logic ELEMENTS_ON,
  input wire logic [15:0] HOLD_TEMP,
  input wire logic [15:0] PREV_HOLD_TEMP,
  input wire logic [15:0] LOCAL_SETPOINT,
  input wire logic BOOT_LONG_OUTAGE,
  input wire logic BOOT_SHORT_OUTAGE,
  input wire logic NVM_WRITE_BUSY,
  input wire logic NVM_MARK_FOUND,
  input wire logic POWER_LOSS_PIN,
  input wire logic KEY_1_PIN,
  input wire logic KEY_ENTER_PIN,
  input wire logic KEY_OTHER_PIN,
  output logic FIRING_STOP,
  output logic ZONE_BALANCE_EN,
  output logic ERROR_CODES_ON,
  output logic NVM_MARK_SET,
  output logic [7:0] ERROR_FLAGS,
  output logic [2:0] SENSOR_FAIL,
  output logic WRITE_ERROR,
  output logic LONG_OUTAGE,
  output logic SHORT_OUTAGE,
  output logic [3:0] DISP_MODE,
  output logic [3:0] DISP_NUM,
  output logic [15:0] DISP_TEMP
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) r = 4'(i + 1);
    end
    return r;
  endfunction

  function automatic logic signed [16:0] diff(input logic [15:0] t,
                                               input logic [15:0] r);
    return $signed({t[15], t}) - $signed({r[15], r});
  endfunction

  function automatic logic over_by(input logic [15:0] t,
                                   input logic [15:0] r);
    return diff(t, r) > DEV_LIMIT;
  endfunction

  function automatic logic under_by(input logic [15:0] t,
                                    input logic [15:0] r);
    return diff(t, r) < -DEV_LIMIT;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and one-second tick
  // ----------------------------------------------------------------
  logic [3:0] pin_m_q, pin_m_d;
  logic [3:0] pin_s_q, pin_s_d;
  logic [3:0] pin_p_q, pin_p_d;
  logic [24:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic [3:0] press;

  always_comb begin
    pin_m_d = {POWER_LOSS_PIN, KEY_OTHER_PIN, KEY_ENTER_PIN, KEY_1_PIN};
    pin_s_d = pin_m_q;
    pin_p_d = pin_s_q;
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 25'h0000001;
    if (tick_cnt_q == 25'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 25'h0000000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pin_m_q <= 4'h0;
      pin_s_q <= 4'h0;
      pin_p_q <= 4'h0;
      tick_cnt_q <= 25'h0000000;
      tick_q <= 1'b0;
    end else begin
      pin_m_q <= pin_m_d;
      pin_s_q <= pin_s_d;
      pin_p_q <= pin_p_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // rising edges only; keys are assumed debounced at the panel
  assign press = pin_s_q & ~pin_p_q;

  // ----------------------------------------------------------------
  // deviation conditions and persistence timers
  // ----------------------------------------------------------------
  logic [15:0] t_mid;
  logic seg_hold, seg_up, seg_down, final_cone;
  logic [NUM_TMR-1:0] dev_cond;
  logic [NUM_TMR-1:0] dev_exp;
  kfm_tmr_if tmr [NUM_TMR] ();

  assign t_mid = TEMP_CH[MID_CH];
  assign seg_hold = FIRING && SEG_TYPE == SEG_HOLD;
  assign seg_up = FIRING && SEG_TYPE == SEG_RAMP_UP;
  assign seg_down = FIRING && SEG_TYPE == SEG_RAMP_DOWN;
  assign final_cone = CONE_MODE && LAST_SEGMENT;

  assign dev_cond[0] = seg_hold && over_by(t_mid, HOLD_TEMP);
  assign dev_cond[1] = seg_hold && under_by(t_mid, HOLD_TEMP);
  assign dev_cond[2] = seg_down && over_by(t_mid, PREV_HOLD_TEMP);
  assign dev_cond[3] = seg_down && under_by(t_mid, LOCAL_SETPOINT);
  assign dev_cond[4] = seg_up && over_by(t_mid, LOCAL_SETPOINT);

  for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
    assign tmr[g].cond = dev_cond[g];
    assign tmr[g].tick = tick_q;
    assign dev_exp[g] = tmr[g].expired;
    kfm_persist u_persist (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .bus(tmr[g])
    );
  end

  // ----------------------------------------------------------------
  // error latches
  // ----------------------------------------------------------------
  kfm_state_type state_q, state_d;
  logic err_en_q, err_en_d;
  logic [7:0] err_q, err_d;
  logic [2:0] fail_q, fail_d;
  logic nvm_err_q, nvm_err_d;
  logic long_q, long_d;
  logic short_q, short_d;
  logic boot_q, boot_d;
  logic mark_q, mark_d;
  logic [8:0] slow_cnt_q, slow_cnt_d;
  logic [15:0] slow_base_q, slow_base_d;
  logic [15:0] prev_t_q, prev_t_d;
  logic stop_q, stop_d;
  logic [7:0] raise;
  logic [7:0] en_mask;
  logic negative;
  logic heating;
  logic key_clear;

  always_comb begin
    negative = 1'b0;
    for (int c = 0; c < 3; c++) begin
      if (TEMP_CH[c][15]) negative = 1'b1;
    end
    heating = seg_up && ELEMENTS_ON;
    key_clear = press[0] && state_q == KFM_IDLE;
    raise = 8'h00;
    raise[ERR_OVER_HOLD] = dev_exp[0];
    raise[ERR_UNDER_HOLD] = dev_exp[1];
    raise[ERR_COOL_OVER] = dev_exp[2];
    raise[ERR_COOL_LAG] = dev_exp[3];
    raise[ERR_HEAT_OVER] = dev_exp[4];
    raise[ERR_REVERSED] = negative;
    // slow climb window restarts whenever heating stops
    slow_cnt_d = slow_cnt_q;
    slow_base_d = slow_base_q;
    if (!heating) begin
      slow_cnt_d = 9'h000;
      slow_base_d = t_mid;
    end else if (tick_q) begin
      if (slow_cnt_q == SLOW_WINDOW_S - 9'h001) begin
        slow_cnt_d = 9'h000;
        slow_base_d = t_mid;
        raise[ERR_SLOW] = diff(t_mid, slow_base_q) < SLOW_MIN_RISE;
      end else begin
        slow_cnt_d = slow_cnt_q + 9'h001;
      end
    end
    prev_t_d = tick_q ? t_mid : prev_t_q;
    if (tick_q && seg_up && final_cone) begin
      raise[ERR_FALLING] = diff(t_mid, prev_t_q) < 17'sh00000;
    end
    // masked codes cannot latch while error codes are off
    en_mask = {8{err_en_q}};
    en_mask[ERR_REVERSED] = 1'b1;
    if (final_cone) begin
      en_mask[ERR_SLOW] = 1'b1;
      en_mask[ERR_FALLING] = 1'b1;
    end
    // a new event in the clearing cycle survives the clear
    err_d = (key_clear ? 8'h00 : err_q) | (raise & en_mask);
    // open inputs only; a shorted input reads ambient and never fails
    fail_d = (FIRING_START ? 3'h0 : fail_q) | TC_OPEN;
    boot_d = 1'b0;
    nvm_err_d = (key_clear ? 1'b0 : nvm_err_q) | (boot_q && NVM_MARK_FOUND);
    // marker stays set if power drops before the write completes
    mark_d = NVM_WRITE_BUSY || (mark_q && pin_s_q[3]);
    long_d = (key_clear ? 1'b0 : long_q) | BOOT_LONG_OUTAGE;
    short_d = (key_clear ? 1'b0 : short_q) | BOOT_SHORT_OUTAGE;
    stop_d = long_q || (|err_q) || (|fail_q) || nvm_err_q;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      err_q <= 8'h00;
      fail_q <= 3'h0;
      nvm_err_q <= 1'b0;
      long_q <= 1'b0;
      short_q <= 1'b0;
      boot_q <= 1'b1;
      mark_q <= 1'b0;
      slow_cnt_q <= 9'h000;
      slow_base_q <= 16'h0000;
      prev_t_q <= 16'h0000;
      stop_q <= 1'b0;
    end else begin
      err_q <= err_d;
      fail_q <= fail_d;
      nvm_err_q <= nvm_err_d;
      long_q <= long_d;
      short_q <= short_d;
      boot_q <= boot_d;
      mark_q <= mark_d;
      slow_cnt_q <= slow_cnt_d;
      slow_base_q <= slow_base_d;
      prev_t_q <= prev_t_d;
      stop_q <= stop_d;
    end
  end

  // ----------------------------------------------------------------
  // error-enable menu and display
  // ----------------------------------------------------------------
  logic pend_q, pend_d;
  logic [1:0] done_cnt_q, done_cnt_d;
  logic blink_q, blink_d;
  logic [3:0] disp_mode_q, disp_mode_d;
  logic [3:0] disp_num_q, disp_num_d;
  logic [15:0] disp_temp_q, disp_temp_d;

  always_comb begin
    state_d = state_q;
    err_en_d = err_en_q;
    pend_d = pend_q;
    done_cnt_d = done_cnt_q;
    blink_d = tick_q ? ~blink_q : blink_q;
    case (state_q)
      KFM_IDLE: begin
        if (press[2] && !FIRING) begin
          state_d = KFM_MENU;
          pend_d = err_en_q;
        end
      end
      KFM_MENU: begin
        if (press[0]) begin
          pend_d = ~pend_q;
        end else if (press[1]) begin
          err_en_d = pend_q;
          done_cnt_d = 2'h0;
          state_d = KFM_DONE;
        end else if (press[2]) begin
          state_d = KFM_IDLE;
        end
      end
      KFM_DONE: begin
        if (tick_q) begin
          done_cnt_d = done_cnt_q + 2'h1;
          if (done_cnt_q == DONE_S - 2'h1) state_d = KFM_IDLE;
        end
      end
      default: begin
        state_d = KFM_IDLE;
      end
    endcase
    disp_temp_d = t_mid;
    disp_num_d = 4'h0;
    // long outage first so nothing else shows while it stands
    if (long_q) begin
      disp_mode_d = DSP_LONG;
    end else if (|fail_q) begin
      disp_mode_d = DSP_FAIL;
      disp_num_d = first_set({5'h00, fail_q});
    end else if (|err_q) begin
      disp_mode_d = DSP_ERROR;
      disp_num_d = first_set(err_q);
    end else if (nvm_err_q) begin
      disp_mode_d = DSP_ERROR;
    end else if (state_q == KFM_MENU) begin
      disp_mode_d = pend_q ? DSP_ON : DSP_OFF;
    end else if (state_q == KFM_DONE) begin
      disp_mode_d = DSP_DONE;
    end else if (short_q) begin
      disp_mode_d = blink_q ? DSP_SHORT : DSP_TEMP;
    end else if (!FIRING) begin
      disp_mode_d = blink_q ? DSP_IDLE : DSP_TEMP;
    end else begin
      disp_mode_d = DSP_TEMP;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= KFM_IDLE;
      err_en_q <= ERR_EN_RST;
      pend_q <= ERR_EN_RST;
      done_cnt_q <= 2'h0;
      blink_q <= 1'b0;
      disp_mode_q <= DSP_TEMP;
      disp_num_q <= 4'h0;
      disp_temp_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      err_en_q <= err_en_d;
      pend_q <= pend_d;
      done_cnt_q <= done_cnt_d;
      blink_q <= blink_d;
      disp_mode_q <= disp_mode_d;
      disp_num_q <= disp_num_d;
      disp_temp_q <= disp_temp_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign FIRING_STOP = stop_q;
  assign ZONE_BALANCE_EN = err_en_q;
  assign ERROR_CODES_ON = err_en_q;
  assign NVM_MARK_SET = mark_q;
  assign ERROR_FLAGS = err_q;
  assign SENSOR_FAIL = fail_q;
  assign WRITE_ERROR = nvm_err_q;
  assign LONG_OUTAGE = long_q;
  assign SHORT_OUTAGE = short_q;
  assign DISP_MODE = disp_mode_q;
  assign DISP_NUM = disp_num_q;
  assign DISP_TEMP = disp_temp_q;

endmodule // kfm_top

// ### kfm_props.sv
// checker on the kiln fault monitor top ports
// assumes one core clock and a small TICK_CYCLES in simulation
`timescale 1ns/1ps
module kfm_props
  import kfm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 6
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [2:0][15:0] TEMP_CH,
  input wire logic [2:0] TC_OPEN,
  input wire logic FIRING,
  input wire logic FIRING_START,
  input wire logic [1:0] SEG_TYPE,
  input wire logic [15:0] HOLD_TEMP,
  input wire logic NVM_MARK_FOUND,
  input wire logic FIRING_STOP,
  input wire logic ZONE_BALANCE_EN,
  input wire logic ERROR_CODES_ON,
  input wire logic [7:0] ERROR_FLAGS,
  input wire logic [2:0] SENSOR_FAIL,
  input wire logic WRITE_ERROR,
  input wire logic LONG_OUTAGE,
  input wire logic SHORT_OUTAGE,
  input wire logic [3:0] DISP_MODE
);
  // ------------------------------------------------------------
  // over-hold run length, signed with one spare bit
  // ------------------------------------------------------------
  logic over_c;
  logic any_err;
  logic [15:0] run_q;
  logic [15:0] run_d;
  assign over_c = FIRING && SEG_TYPE == SEG_HOLD &&
    ($signed({TEMP_CH[1][15], TEMP_CH[1]}) -
     $signed({HOLD_TEMP[15], HOLD_TEMP}) > DEV_LIMIT);
  assign any_err = |ERROR_FLAGS || |SENSOR_FAIL || WRITE_ERROR || LONG_OUTAGE;
  always_comb begin
    run_d = over_c ? run_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge CORE_CLK) begin
    run_q <= RST_N ? run_d : 16'h0000;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  chk_codes_boot: assert property ($rose(RST_N) |-> ERROR_CODES_ON)
    else $error("codes not on after reset");
  chk_zone_follow: assert property (
    ZONE_BALANCE_EN == ERROR_CODES_ON)
    else $error("zone balance differs from code enable");
  chk_reversed_set: assert property ((TEMP_CH[0][15] || TEMP_CH[1][15] ||
    TEMP_CH[2][15]) |=> ERROR_FLAGS[ERR_REVERSED])
    else $error("negative reading not flagged");
  chk_stop_cause: assert property (any_err |=> FIRING_STOP)
    else $error("error latched but elements not stopped");
  chk_short_runs: assert property (
    SHORT_OUTAGE && !any_err |=> !FIRING_STOP)
    else $error("short outage stopped the firing");
  chk_long_only: assert property (
    LONG_OUTAGE ##1 LONG_OUTAGE |-> DISP_MODE == DSP_LONG)
    else $error("long outage not shown alone");
  chk_hold_late: assert property (run_q >= 19 * TICK_CYCLES + 4 &&
    ERROR_CODES_ON |-> ERROR_FLAGS[ERR_OVER_HOLD])
    else $error("over-hold not raised in time");
  chk_hold_early: assert property ($rose(ERROR_FLAGS[ERR_OVER_HOLD]) |->
    $past(run_q) >= 18 * TICK_CYCLES)
    else $error("over-hold raised before 18 s");
  chk_fail_chan: assert property (TC_OPEN[2] && !FIRING_START |->
    ##[1:2] SENSOR_FAIL[2])
    else $error("channel 3 failure not reported");
  chk_boot_mark: assert property ($rose(RST_N) && NVM_MARK_FOUND |->
    ##[1:2] WRITE_ERROR)
    else $error("interrupted write not reported");

  cover property ($rose(ERROR_FLAGS[ERR_OVER_HOLD]));
  cover property (SHORT_OUTAGE && DISP_MODE == DSP_SHORT);
  cover property ($fell(ERROR_CODES_ON));
endmodule // kfm_props

bind kfm_top kfm_props #(.TICK_CYCLES(TICK_CYCLES)) kfm_props_i (
  .CORE_CLK, .RST_N, .TEMP_CH, .TC_OPEN, .FIRING, .FIRING_START, .SEG_TYPE,
  .HOLD_TEMP, .NVM_MARK_FOUND, .FIRING_STOP, .ZONE_BALANCE_EN,
  .ERROR_CODES_ON, .ERROR_FLAGS, .SENSOR_FAIL, .WRITE_ERROR, .LONG_OUTAGE,
  .SHORT_OUTAGE, .DISP_MODE);

// ### kfm_operator.sv
// operator model: presses keys and reads the display
// assumes keys pass a two-stage sync on CORE_CLK
`timescale 1ns/1ps
module kfm_operator
  import kfm_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic [3:0] DISP_MODE,
  output logic KEY_1_PIN,
  output logic KEY_ENTER_PIN,
  output logic KEY_OTHER_PIN
);
  initial begin
    {KEY_1_PIN, KEY_ENTER_PIN, KEY_OTHER_PIN} = 3'h0;
  end

  // k: 0 key 1, 1 enter, 2 other; held well past the sync delay
  task automatic press(input int k);
    @(negedge CORE_CLK);
    KEY_1_PIN = (k == 0);
    KEY_ENTER_PIN = (k == 1);
    KEY_OTHER_PIN = (k == 2);
    repeat (5) @(negedge CORE_CLK);
    {KEY_1_PIN, KEY_ENTER_PIN, KEY_OTHER_PIN} = 3'h0;
    repeat (5) @(negedge CORE_CLK);
  endtask

  // toggle until the wanted word shows, at most a few tries
  task automatic set_codes(input logic on);
    int n;
    n = 0;
    press(2);
    while (DISP_MODE !== (on ? DSP_ON : DSP_OFF) && n < 3) begin
      press(0);
      n++;
    end
    press(1);
  endtask
endmodule // kfm_operator

// ### kiln_fault_monitor_bench.sv
// self-checking bench for the kiln fault monitor top module
// assumes kfm_pkg, kfm_top, kfm_props and kfm_operator compile first
`timescale 1ns/1ps
module kiln_fault_monitor_bench
  import kfm_pkg::*;
();
  localparam int T = 6;
  logic CORE_CLK, RST_N, FIRING, FIRING_START, CONE_MODE, LAST_SEGMENT;
  logic ELEMENTS_ON, BOOT_LONG_OUTAGE, BOOT_SHORT_OUTAGE, NVM_WRITE_BUSY;
  logic NVM_MARK_FOUND, POWER_LOSS_PIN, NVM_MARK_SET, KEY_1_PIN;
  logic KEY_ENTER_PIN, KEY_OTHER_PIN, FIRING_STOP, ZONE_BALANCE_EN;
  logic ERROR_CODES_ON, WRITE_ERROR, LONG_OUTAGE, SHORT_OUTAGE;
  logic [2:0][15:0] TEMP_CH;
  logic [2:0] TC_OPEN, SENSOR_FAIL;
  logic [1:0] SEG_TYPE;
  logic [15:0] HOLD_TEMP, PREV_HOLD_TEMP, LOCAL_SETPOINT, DISP_TEMP;
  logic [7:0] ERROR_FLAGS;
  logic [3:0] DISP_MODE, DISP_NUM;
  int err_count = 0;
  int num_checks = 0;
  int exp_flags = 0;
  int segs[5] = '{3, 3, 2, 2, 1};
  int bits[5] = '{1, 2, 3, 4, 6};
  int sgns[5] = '{1, -1, 1, -1, 1};

  kfm_top #(.TICK_CYCLES(T)) kfm_top_i (.CORE_CLK, .RST_N, .TEMP_CH,
    .TC_OPEN, .FIRING, .FIRING_START, .SEG_TYPE, .CONE_MODE, .LAST_SEGMENT,
    .ELEMENTS_ON, .HOLD_TEMP, .PREV_HOLD_TEMP, .LOCAL_SETPOINT,
    .BOOT_LONG_OUTAGE, .BOOT_SHORT_OUTAGE, .NVM_WRITE_BUSY, .NVM_MARK_FOUND,
    .POWER_LOSS_PIN, .KEY_1_PIN, .KEY_ENTER_PIN, .KEY_OTHER_PIN,
    .FIRING_STOP, .ZONE_BALANCE_EN, .ERROR_CODES_ON, .NVM_MARK_SET,
    .ERROR_FLAGS, .SENSOR_FAIL, .WRITE_ERROR, .LONG_OUTAGE, .SHORT_OUTAGE,
    .DISP_MODE, .DISP_NUM, .DISP_TEMP);
  kfm_operator kfm_operator_i (.CORE_CLK, .DISP_MODE, .KEY_1_PIN,
    .KEY_ENTER_PIN, .KEY_OTHER_PIN);

  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // ------------------------------------------------------------
  // compares, model of the latched codes, closing
  // ------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string s);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %b", $time, s, got);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                         input string s);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_flags();
    chk_val({8'h00, ERROR_FLAGS}, 16'(exp_flags), "flags");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  // key 1 in the idle state clears every latched code except sensor fail
  task automatic key1();
    kfm_operator_i.press(0);
    exp_flags = 0;
  endtask
  task automatic outage(input logic lng);
    BOOT_LONG_OUTAGE = lng;
    BOOT_SHORT_OUTAGE = !lng;
    cyc(1);
    {BOOT_LONG_OUTAGE, BOOT_SHORT_OUTAGE} = 2'h0;
    cyc(3);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // far above the roughly 5100 cycles the sequence takes
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    end_sim();
  end

  initial begin
    int k;
    int d;
    int n3;
    int n0;
    void'($urandom(32'hC2BB));
    RST_N = 1'b0;
    {FIRING, FIRING_START, CONE_MODE, LAST_SEGMENT, ELEMENTS_ON} = 5'h00;
    {BOOT_LONG_OUTAGE, BOOT_SHORT_OUTAGE, NVM_WRITE_BUSY} = 3'h0;
    {POWER_LOSS_PIN, NVM_MARK_FOUND} = 2'h1;
    TEMP_CH = '0;
    TC_OPEN = 3'h0;
    SEG_TYPE = SEG_IDLE;
    HOLD_TEMP = 16'h03E8;
    PREV_HOLD_TEMP = 16'h03E8;
    LOCAL_SETPOINT = 16'h03E8;
    cyc(6);
    RST_N = 1'b1;
    cyc(1);
    NVM_MARK_FOUND = 1'b0;
    cyc(2);
    chk_bit(ERROR_CODES_ON, 1'b1, "codes on");
    chk_bit(WRITE_ERROR, 1'b1, "write err");
    key1();
    chk_bit(WRITE_ERROR, 1'b0, "write clr");
    NVM_WRITE_BUSY = 1'b1;
    POWER_LOSS_PIN = 1'b1;
    cyc(4);
    NVM_WRITE_BUSY = 1'b0;
    cyc(2);
    chk_bit(NVM_MARK_SET, 1'b1, "mark held");
    POWER_LOSS_PIN = 1'b0;
    cyc(5);
    chk_bit(NVM_MARK_SET, 1'b0, "mark off");
    // ------------------------------------------------------------
    // deviation codes: boundary, one-cycle dropout, then persist
    // ------------------------------------------------------------
    FIRING = 1'b1;
    for (k = 0; k < 5; k++) begin
      SEG_TYPE = 2'(segs[k]);
      TEMP_CH[0] = 16'($urandom_range(20, 2000));
      TEMP_CH[1] = 16'(1000 + sgns[k] * 50);
      d = 51 + $urandom_range(0, 200);
      cyc(20 * T + 4);
      chk_flags();
      TEMP_CH[1] = 16'(1000 + sgns[k] * d);
      cyc(17 * T);
      TEMP_CH[1] = 16'h03E8;
      cyc(1);
      TEMP_CH[1] = 16'(1000 + sgns[k] * d);
      cyc(17 * T);
      chk_flags();
      cyc(3 * T + 4);
      exp_flags = 1 << bits[k];
      chk_flags();
      chk_bit(FIRING_STOP, 1'b1, "stop");
      chk_val(16'(DISP_NUM), 16'(bits[k] + 1), "code");
      TEMP_CH[1] = 16'h03E8;
      key1();
      chk_flags();
    end
    SEG_TYPE = SEG_RAMP_UP;
    ELEMENTS_ON = 1'b1;
    cyc(482 * T + 4);
    exp_flags = 1;
    chk_flags();
    ELEMENTS_ON = 1'b0;
    key1();
    // ------------------------------------------------------------
    // codes off: menu, masking, never-masked codes
    // ------------------------------------------------------------
    FIRING = 1'b0;
    kfm_operator_i.set_codes(1'b0);
    chk_bit(ZONE_BALANCE_EN, 1'b0, "zone off");
    chk_val(16'(DISP_MODE), 16'(DSP_DONE), "done");
    cyc(4 * T + 4);
    // idle word blinks with the temperature, so watch two seconds
    n3 = 0;
    n0 = 0;
    repeat (2 * T) begin
      cyc(1);
      n3 += int'(DISP_MODE === DSP_IDLE);
      n0 += int'(DISP_MODE === DSP_DONE);
    end
    chk_bit(n3 > 0 && n0 == 0, 1'b1, "idle");
    FIRING = 1'b1;
    SEG_TYPE = SEG_HOLD;
    TEMP_CH[1] = 16'h0424;
    cyc(20 * T + 4);
    chk_flags();
    TEMP_CH[1] = 16'h03E8;
    TEMP_CH[2] = 16'hFFF6;
    cyc(2);
    exp_flags = 32;
    chk_flags();
    TEMP_CH[2] = 16'h0014;
    key1();
    TC_OPEN = 3'h4;
    cyc(3);
    chk_val(16'(SENSOR_FAIL), 16'h0004, "fail");
    chk_val(16'(DISP_NUM), 16'h0003, "fail ch");
    TC_OPEN = 3'h0;
    FIRING_START = 1'b1;
    cyc(1);
    FIRING_START = 1'b0;
    {CONE_MODE, LAST_SEGMENT} = 2'h3;
    SEG_TYPE = SEG_RAMP_UP;
    repeat (4) begin
      TEMP_CH[1] = TEMP_CH[1] - 16'h0005;
      cyc(T);
    end
    exp_flags = 128;
    chk_flags();
    {CONE_MODE, LAST_SEGMENT, FIRING} = 3'h0;
    key1();
    kfm_operator_i.set_codes(1'b1);
    chk_bit(ERROR_CODES_ON, 1'b1, "codes back");
    cyc(4 * T);
    // ------------------------------------------------------------
    // outages
    // ------------------------------------------------------------
    FIRING = 1'b1;
    SEG_TYPE = SEG_HOLD;
    outage(1'b0);
    n3 = 0;
    n0 = 0;
    repeat (3 * T) begin
      cyc(1);
      n3 += int'(DISP_MODE === DSP_SHORT);
      n0 += int'(DISP_MODE === DSP_TEMP);
    end
    chk_bit(n3 > 0 && n0 > 0, 1'b1, "blink");
    chk_val(DISP_TEMP, 16'h03D4, "temp");
    chk_bit(FIRING_STOP, 1'b0, "short runs");
    key1();
    chk_bit(SHORT_OUTAGE, 1'b0, "short clr");
    outage(1'b1);
    chk_bit(FIRING_STOP, 1'b1, "long stop");
    chk_val(16'(DISP_MODE), 16'(DSP_LONG), "long");
    key1();
    chk_bit(LONG_OUTAGE, 1'b0, "long clr");
    chk_flags();
    end_sim();
  end
endmodule // kiln_fault_monitor_bench
